//--- phc_device.sv
`timescale 1ns/1ps
`include "phc_consts.svh"
module phc_device
  import phc_pkg::*;
(
  input wire logic clk_i, // System clock.
  input wire logic rst_n_i, // Synchronous reset, active low.
  phc_if.dev link, // Host-side pins.
  input wire logic [3:0] address_sense_input_i, // Code 1..15 read from the sense resistor.
  input wire logic [`PHC_MSG_BITS-1:0] reply_msg_i, // Reply message, first byte in the top bits.
  input wire logic reply_load_i, // Pulse: latch the reply and mark it pending.
  output logic [`PHC_MSG_BITS-1:0] rx_msg_o, // Last message written by the host.
  output logic rx_done_o, // Pulse: a full message has arrived.
  input wire logic [`PHC_EVT_BITS-1:0] event_i, // Live event levels.
  input wire logic [`PHC_EVT_BITS-1:0] event_en_i, // Events chosen to interrupt.
  input wire logic [`PHC_COND_BITS-1:0] cond_ok_i, // Live good levels of conditions.
  input wire logic [`PHC_COND_BITS-1:0] cond_mask_i, // Conditions that affect system-valid.
  input wire logic [`PHC_LED_BITS-1:0] led_pattern_i, // Status pattern to stream out.
  input wire logic led_enable_i, // Enables the status drivers.
  input wire logic power_good_in_1_i, // Power-good input 1.
  input wire logic power_good_in_2_i, // Power-good input 2.
  input wire logic power_good_in_3_i, // Power-good input 3.
  input wire logic power_good_in_4_i, // Power-good input 4.
  output logic [3:0] power_good_o, // Synchronised power-good levels.
  output logic ports_off_o, // High while all ports must be shut down.
  output logic status_stream_clock_o, // Status stream clock.
  output logic status_stream_select_n_o, // Status stream select, active low.
  output logic status_stream_dout_o, // Status stream data.
  output logic status_stream_out_en_n_o // Status driver enable, active low.
);
  // ----------------------------------------------------------------
  // Input synchronisers.
  // ----------------------------------------------------------------
  logic [6:0] sync_a; // First stage for the slow inputs.
  logic [6:0] sync_b; // Second stage for the slow inputs.
  logic scl_c; // Third stage of the link clock, for edges.
  logic sda_c; // Third stage of the data line, for edges.

  // Two flip-flops on each of these seven pins; the first stage feeds only the second.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync_a <= 7'h7f;
      sync_b <= 7'h7f;
    end else begin
      sync_a <= {link.scl, link.sda, link.host_reset_n, link.all_ports_off_n,
                 power_good_in_4_i, power_good_in_3_i, power_good_in_2_i};
      sync_b <= sync_a;
    end
  end

  logic pg1_a; // First stage of power-good 1.
  logic pg1_b; // Second stage of power-good 1.

  // Power-good 1 has its own pair, which resets low where the vector above resets high.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pg1_a <= 1'b0;
      pg1_b <= 1'b0;
    end else begin
      pg1_a <= power_good_in_1_i;
      pg1_b <= pg1_a;
    end
  end

  logic scl_s; // Synchronised link clock.
  logic sda_s; // Synchronised data line.
  logic run; // Low while either reset is active.
  assign scl_s = sync_b[6];
  assign sda_s = sync_b[5];
  assign run = rst_n_i & sync_b[4];

  // Edge stages for the link lines.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      scl_c <= 1'b1;
      sda_c <= 1'b1;
    end else begin
      scl_c <= scl_s;
      sda_c <= sda_s;
    end
  end

  logic scl_rise; // Link clock rising edge.
  logic scl_fall; // Link clock falling edge.
  logic start_seen; // Data falls while clock is high.
  logic stop_seen; // Data rises while clock is high.
  assign scl_rise = scl_s & ~scl_c;
  assign scl_fall = ~scl_s & scl_c;
  assign start_seen = scl_s & scl_c & sda_c & ~sda_s;
  assign stop_seen = scl_s & scl_c & ~sda_c & sda_s;

  // ----------------------------------------------------------------
  // Status pins.
  // ----------------------------------------------------------------
  // Registered status levels; the masked conditions must all be good.
  always_ff @(posedge clk_i) begin
    if (!run) begin
      power_good_o <= 4'h0;
      ports_off_o <= 1'b0;
      link.irq_oe <= 1'b0;
      link.system_valid_n <= 1'b1;
    end else begin
      power_good_o <= {sync_b[2:0], pg1_b};
      ports_off_o <= ~sync_b[3];
      link.irq_oe <= |(event_i & event_en_i);
      link.system_valid_n <= ~(&(cond_ok_i | ~cond_mask_i));
    end
  end

  // ----------------------------------------------------------------
  // Target address.
  // ----------------------------------------------------------------
  logic [6:0] my_addr; // Address from the sense code, updated every cycle out of reset.

  // The sense code is taken every cycle out of reset and held as the address.
  always_ff @(posedge clk_i) begin
    if (!run) begin
      my_addr <= 7'h00;
    end else begin
      my_addr <= 7'(address_sense_input_i * `PHC_ADDR_STEP);
    end
  end

  // ----------------------------------------------------------------
  // Link target.
  // ----------------------------------------------------------------
  phc_tgt_e st; // Target state.
  logic [3:0] bitcnt; // Bits done in the current byte.
  logic [3:0] bytecnt; // Data bytes done in the current message.
  logic [7:0] shreg; // Byte shift register.
  logic [`PHC_MSG_BITS-1:0] reply_buf; // Reply bytes still to be sent.
  logic acked; // Host acknowledged the last read byte.
  logic read_done; // Pulse: the last reply byte went out.

  // Bit-level target engine, no clock stretching is needed at this link rate.
  always_ff @(posedge clk_i) begin
    read_done <= 1'b0;
    rx_done_o <= 1'b0;
    if (!run) begin
      st <= PHC_T_IDLE;
      bitcnt <= 4'h0;
      bytecnt <= 4'h0;
      shreg <= 8'h00;
      acked <= 1'b0;
      rx_msg_o <= '0;
      link.dev_sda_oe <= 1'b0;
    end else if (stop_seen) begin
      // A stop ends any transfer and releases the line.
      st <= PHC_T_IDLE;
      link.dev_sda_oe <= 1'b0;
    end else if (start_seen) begin
      // A start, repeated or not, begins a new address byte.
      st <= PHC_T_ADDR;
      bitcnt <= 4'h0;
      bytecnt <= 4'h0;
      link.dev_sda_oe <= 1'b0;
    end else if (scl_rise) begin
      case (st)
        PHC_T_ADDR, PHC_T_WR: begin
          shreg <= {shreg[6:0], sda_s};
          bitcnt <= bitcnt + 4'h1;
        end
        PHC_T_ACK_R: begin
          acked <= ~sda_s;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (st)
        PHC_T_ADDR: begin
          if (bitcnt == 4'h8) begin
            // Reads are answered only while a reply is pending.
            if (shreg[7:1] == my_addr && (!shreg[0] || !link.reply_pending_n)) begin
              st <= PHC_T_ACK_A;
              link.dev_sda_oe <= 1'b1;
            end else begin
              st <= PHC_T_IDLE;
            end
          end
        end
        PHC_T_ACK_A: begin
          if (shreg[0]) begin
            // First reply bit goes out right after the address acknowledge.
            st <= PHC_T_RD;
            shreg <= reply_buf[`PHC_MSG_BITS-1 -: 8];
            link.dev_sda_oe <= ~reply_buf[`PHC_MSG_BITS-1];
            bitcnt <= 4'h1;
          end else begin
            st <= PHC_T_WR;
            link.dev_sda_oe <= 1'b0;
            bitcnt <= 4'h0;
          end
        end
        PHC_T_WR: begin
          if (bitcnt == 4'h8) begin
            // Bytes past the fifteenth are refused with a not-acknowledge.
            if (bytecnt < 4'(`PHC_MSG_BYTES)) begin
              st <= PHC_T_ACK_W;
              link.dev_sda_oe <= 1'b1;
              rx_msg_o <= {rx_msg_o[`PHC_MSG_BITS-9:0], shreg};
              bytecnt <= bytecnt + 4'h1;
              rx_done_o <= (bytecnt == 4'(`PHC_MSG_BYTES - 1));
            end else begin
              st <= PHC_T_IDLE;
            end
          end
        end
        PHC_T_ACK_W: begin
          st <= PHC_T_WR;
          link.dev_sda_oe <= 1'b0;
          bitcnt <= 4'h0;
        end
        PHC_T_RD: begin
          if (bitcnt == 4'h8) begin
            st <= PHC_T_ACK_R;
            link.dev_sda_oe <= 1'b0;
          end else begin
            shreg <= {shreg[6:0], 1'b0};
            link.dev_sda_oe <= ~shreg[6];
            bitcnt <= bitcnt + 4'h1;
          end
        end
        PHC_T_ACK_R: begin
          bytecnt <= bytecnt + 4'h1;
          read_done <= (bytecnt == 4'(`PHC_MSG_BYTES - 1));
          if (acked && bytecnt < 4'(`PHC_MSG_BYTES - 1)) begin
            // Next reply byte; the buffer already moved on by one byte.
            st <= PHC_T_RD;
            shreg <= reply_buf[`PHC_MSG_BITS-1 -: 8];
            link.dev_sda_oe <= ~reply_buf[`PHC_MSG_BITS-1];
            bitcnt <= 4'h1;
          end else begin
            st <= PHC_T_IDLE;
          end
        end
        default: begin
          st <= PHC_T_IDLE;
        end
      endcase
    end
  end

  // Reply buffer: loaded by the user, moved one byte on as each byte is taken.
  always_ff @(posedge clk_i) begin
    if (!run) begin
      reply_buf <= '0;
    end else if (reply_load_i) begin
      reply_buf <= reply_msg_i;
    end else if (scl_fall && !stop_seen && !start_seen &&
                 ((st == PHC_T_ACK_A && shreg[0]) || st == PHC_T_ACK_R)) begin
      reply_buf <= {reply_buf[`PHC_MSG_BITS-9:0], 8'h00};
    end
  end

  // Pending line: a new reply wins over the end of the read in the same cycle.
  always_ff @(posedge clk_i) begin
    if (!run) begin
      link.reply_pending_n <= 1'b1;
    end else if (reply_load_i) begin
      link.reply_pending_n <= 1'b0;
    end else if (read_done) begin
      link.reply_pending_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Status stream.
  // ----------------------------------------------------------------
  logic [4:0] led_div; // Half-period divider.
  logic led_tick; // One-cycle enable at each half period.
  logic [4:0] led_bit; // Bits sent in the current frame.
  logic [`PHC_LED_BITS-1:0] led_sh; // Frame shift register.
  assign led_tick = (led_div == 5'(`PHC_LED_HALF_CYC - 1));

  // Divider for the stream clock.
  always_ff @(posedge clk_i) begin
    if (!run) begin
      led_div <= 5'h00;
    end else begin
      led_div <= led_tick ? 5'h00 : led_div + 5'h01;
    end
  end

  // Frames repeat: select low for sixteen clocks, then one idle half period with select high.
  always_ff @(posedge clk_i) begin
    if (!run) begin
      led_bit <= 5'h00;
      led_sh <= '0;
      status_stream_clock_o <= 1'b0;
      status_stream_select_n_o <= 1'b1;
      status_stream_dout_o <= 1'b0;
    end else if (led_tick) begin
      if (status_stream_clock_o) begin
        // Falling edge: the target latched on the rise, so the next bit goes out half a period early.
        status_stream_clock_o <= 1'b0;
        led_sh <= {led_sh[`PHC_LED_BITS-2:0], 1'b0};
        status_stream_dout_o <= led_sh[`PHC_LED_BITS-2];
        led_bit <= led_bit + 5'h01;
      end else if (led_bit == 5'(`PHC_LED_BITS)) begin
        // Idle bit: the first bit of the new pattern is set up while select is high.
        status_stream_select_n_o <= 1'b1;
        status_stream_dout_o <= led_pattern_i[`PHC_LED_BITS-1];
        led_bit <= 5'h00;
        led_sh <= led_pattern_i;
      end else begin
        // Rising edge: data has stood since the last falling edge or the idle bit, so it never moves with the clock.
        status_stream_select_n_o <= 1'b0;
        status_stream_clock_o <= 1'b1;
      end
    end
  end

  // Driver enable follows the user enable.
  always_ff @(posedge clk_i) begin
    if (!run) begin
      status_stream_out_en_n_o <= 1'b1;
    end else begin
      status_stream_out_en_n_o <= ~led_enable_i;
    end
  end
endmodule

//--- phc_consts.svh
`ifndef PHC_CONSTS_SVH
`define PHC_CONSTS_SVH
// Bytes in one protocol message in either direction.
`define PHC_MSG_BYTES 15
// Bits in one protocol message.
`define PHC_MSG_BITS 120
// Fastest host link clock, in kHz.
`define PHC_SCL_MAX_KHZ 400
// System clock rate, in kHz.
`define PHC_CLK_KHZ 125000
// Quarter link-clock period in system cycles, rounded up so the link never runs fast.
`define PHC_QTR_CYC ((`PHC_CLK_KHZ + 4 * `PHC_SCL_MAX_KHZ - 1) / (4 * `PHC_SCL_MAX_KHZ))
// Spacing between target addresses chosen by the sense resistor.
`define PHC_ADDR_STEP 4
// Half period of the status stream clock, in system cycles.
`define PHC_LED_HALF_CYC 16
// Bits in one status stream frame.
`define PHC_LED_BITS 16
// Events that may raise the host interrupt.
`define PHC_EVT_BITS 8
// Conditions that may affect the system-valid output.
`define PHC_COND_BITS 8
`endif

//--- phc_pkg.sv
package phc_pkg;
  // Target side link states.
  typedef enum logic [2:0] {
    PHC_T_IDLE,
    PHC_T_ADDR,
    PHC_T_ACK_A,
    PHC_T_WR,
    PHC_T_ACK_W,
    PHC_T_RD,
    PHC_T_ACK_R
  } phc_tgt_e;
  // Host side link states.
  typedef enum logic [1:0] {
    PHC_H_IDLE,
    PHC_H_START,
    PHC_H_BIT,
    PHC_H_STOP
  } phc_hst_e;
endpackage

//--- phc_if.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Pins between the host processor and the controller.
// ----------------------------------------------------------------
interface phc_if;
  logic scl_oe; // Host pulls the link clock low.
  logic host_sda_oe; // Host pulls the data line low.
  logic dev_sda_oe; // Controller pulls the data line low.
  logic irq_oe; // Controller pulls the interrupt line low.
  logic system_valid_n; // Push-pull system-valid level.
  logic reply_pending_n; // Low while a reply waits to be read.
  logic all_ports_off_n; // Low asks the controller to shut all ports.
  logic host_reset_n; // Low holds the controller in reset.
  logic scl; // Resolved link clock with pull-up.
  logic sda; // Resolved data line with pull-up.
  logic host_irq_n; // Resolved interrupt line with internal pull-up.
  assign scl = ~scl_oe;
  assign sda = ~(host_sda_oe | dev_sda_oe);
  assign host_irq_n = ~irq_oe;
  modport dev (input scl, input sda, input all_ports_off_n, input host_reset_n,
               output dev_sda_oe, output irq_oe, output system_valid_n, output reply_pending_n);
  modport host (input sda, input host_irq_n, input system_valid_n, input reply_pending_n,
                output scl_oe, output host_sda_oe, output all_ports_off_n, output host_reset_n);
endinterface

//--- phc_host.sv
`timescale 1ns/1ps
`include "phc_consts.svh"
module phc_host
  import phc_pkg::*;
(
  input wire logic clk_i, // System clock.
  input wire logic rst_n_i, // Synchronous reset, active low.
  phc_if.host link, // Pins toward the controller.
  input wire logic [6:0] addr_i, // Controller target address.
  input wire logic go_i, // Pulse: start a transfer.
  input wire logic rd_i, // With go_i: read instead of write.
  input wire logic [`PHC_MSG_BITS-1:0] tx_msg_i, // Message to write, first byte on top.
  output logic [`PHC_MSG_BITS-1:0] rx_msg_o, // Reply read back.
  output logic done_o, // Pulse: transfer finished.
  output logic nack_o, // Last transfer's address or a written byte was not acknowledged.
  output logic busy_o, // Transfer in progress.
  output logic reply_ready_o, // Synchronised pending indication.
  output logic irq_o, // Synchronised interrupt, active high.
  output logic system_valid_o, // Synchronised system-valid, active high.
  input wire logic reset_dev_i, // Hold the controller in reset.
  input wire logic ports_off_i // Ask the controller to shut all ports.
);
  // ----------------------------------------------------------------
  // Synchronisers and control pins.
  // ----------------------------------------------------------------
  logic [3:0] sy_a; // First stage.
  logic [3:0] sy_b; // Second stage.

  // Pins from the controller pass two flip-flops.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sy_a <= 4'hf;
      sy_b <= 4'hf;
    end else begin
      sy_a <= {link.sda, link.reply_pending_n, link.host_irq_n, link.system_valid_n};
      sy_b <= sy_a;
    end
  end

  // Registered status and control levels.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      reply_ready_o <= 1'b0;
      irq_o <= 1'b0;
      system_valid_o <= 1'b0;
      link.host_reset_n <= 1'b0;
      link.all_ports_off_n <= 1'b1;
    end else begin
      reply_ready_o <= ~sy_b[2];
      irq_o <= ~sy_b[1];
      system_valid_o <= ~sy_b[0];
      link.host_reset_n <= ~reset_dev_i;
      link.all_ports_off_n <= ~ports_off_i;
    end
  end

  // ----------------------------------------------------------------
  // Link master.
  // ----------------------------------------------------------------
  logic [6:0] qdiv; // Quarter-period divider.
  logic qtick; // One-cycle enable per quarter period.
  assign qtick = (qdiv == 7'(`PHC_QTR_CYC - 1));

  // Quarter-period divider, running only during a transfer.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !busy_o) begin
      qdiv <= 7'h00;
    end else begin
      qdiv <= qtick ? 7'h00 : qdiv + 7'h01;
    end
  end

  phc_hst_e st; // Master state.
  logic [1:0] ph; // Quarter within a bit.
  logic [3:0] bitcnt; // Bit in byte, eight is the acknowledge.
  logic [3:0] bytecnt; // Data bytes done.
  logic [7:0] shreg; // Byte shift register.
  logic [`PHC_MSG_BITS-1:0] tx_buf; // Bytes still to write.
  logic rd; // Current transfer reads.
  logic in_addr; // Address byte in flight.
  logic last_rx; // Byte being read is the last.
  assign busy_o = (st != PHC_H_IDLE);
  assign last_rx = (bytecnt == 4'(`PHC_MSG_BYTES - 1));

  // Start, bits with acknowledge, stop; a read starts only while a reply is pending.
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (!rst_n_i) begin
      st <= PHC_H_IDLE;
      ph <= 2'h0;
      bitcnt <= 4'h0;
      bytecnt <= 4'h0;
      shreg <= 8'h00;
      tx_buf <= '0;
      rd <= 1'b0;
      in_addr <= 1'b0;
      nack_o <= 1'b0;
      rx_msg_o <= '0;
      link.scl_oe <= 1'b0;
      link.host_sda_oe <= 1'b0;
    end else if (st == PHC_H_IDLE) begin
      if (go_i && (!rd_i || !sy_b[2])) begin
        st <= PHC_H_START;
        ph <= 2'h0;
        rd <= rd_i;
        tx_buf <= tx_msg_i;
        shreg <= {addr_i, rd_i};
        in_addr <= 1'b1;
        bitcnt <= 4'h0;
        bytecnt <= 4'h0;
        nack_o <= 1'b0;
      end
    end else if (qtick) begin
      ph <= ph + 2'h1;
      case (st)
        PHC_H_START: begin
          if (ph == 2'h1) link.host_sda_oe <= 1'b1;
          if (ph == 2'h2) link.scl_oe <= 1'b1;
          if (ph == 2'h3) st <= PHC_H_BIT;
        end
        PHC_H_BIT: begin
          case (ph)
            2'h0: begin
              if (bitcnt == 4'h8) begin
                // Host acknowledges every read byte except the last.
                link.host_sda_oe <= rd && !in_addr && !last_rx;
              end else begin
                link.host_sda_oe <= (rd && !in_addr) ? 1'b0 : ~shreg[7];
              end
            end
            2'h1: link.scl_oe <= 1'b0;
            2'h2: begin
              if (bitcnt == 4'h8) begin
                if (!rd || in_addr) nack_o <= sy_b[3];
              end else if (rd && !in_addr) begin
                shreg <= {shreg[6:0], sy_b[3]};
              end
            end
            default: begin
              link.scl_oe <= 1'b1;
              if (bitcnt != 4'h8) begin
                bitcnt <= bitcnt + 4'h1;
                if (!rd || in_addr) shreg <= {shreg[6:0], 1'b0};
              end else begin
                bitcnt <= 4'h0;
                in_addr <= 1'b0;
                if (!in_addr) bytecnt <= bytecnt + 4'h1;
                if (rd && !in_addr) rx_msg_o <= {rx_msg_o[`PHC_MSG_BITS-9:0], shreg};
                if (nack_o || (!in_addr && bytecnt == 4'(`PHC_MSG_BYTES - 1))) begin
                  st <= PHC_H_STOP;
                end else if (!rd) begin
                  shreg <= tx_buf[`PHC_MSG_BITS-1 -: 8];
                  tx_buf <= {tx_buf[`PHC_MSG_BITS-9:0], 8'h00};
                end
              end
            end
          endcase
        end
        PHC_H_STOP: begin
          if (ph == 2'h0) link.host_sda_oe <= 1'b1;
          if (ph == 2'h1) link.scl_oe <= 1'b0;
          if (ph == 2'h2) link.host_sda_oe <= 1'b0;
          if (ph == 2'h3) begin
            st <= PHC_H_IDLE;
            done_o <= 1'b1;
          end
        end
        default: st <= PHC_H_IDLE;
      endcase
    end
  end
endmodule

//--- phc_checker.sv
`timescale 1ns/1ps
// ---
// Link timing and reset checks.
// ---
module phc_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic scl,
  input wire logic dev_sda_oe,
  input wire logic irq_oe,
  input wire logic system_valid_n,
  input wire logic reply_pending_n,
  input wire logic host_reset_n
);
  logic [8:0] since_rise; // Cycles since the link clock last rose.
  // Times the link clock period, saturating while the link is idle.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) since_rise <= 9'h1ff;
    else if ($rose(scl)) since_rise <= 9'h000;
    else if (since_rise != 9'h1ff) since_rise <= since_rise + 9'h001;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  rst_idle_a: assert property ($rose(rst_n_i) |-> reply_pending_n && !irq_oe && !dev_sda_oe)
    else $error("busy after reset");
  host_rst_a: assert property (!host_reset_n [*5] |=> reply_pending_n && !irq_oe && system_valid_n)
    else $error("host reset ignored");
  sda_on_a: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("data set while clock high");
  sda_hold_a: assert property ($rose(dev_sda_oe) |=> dev_sda_oe [*8])
    else $error("data bit too short");
  sda_off_a: assert property ($fell(dev_sda_oe) |-> !scl)
    else $error("data freed while clock high");
  pend_set_a: assert property ($fell(reply_pending_n) |=> !reply_pending_n [*8])
    else $error("reply pending dropped");
  pend_clr_a: assert property ($rose(reply_pending_n) && host_reset_n |-> !scl)
    else $error("pending cleared mid bit");
  scl_rate_a: assert property ($rose(scl) |-> since_rise >= 9'h138)
    else $error("link clock too fast");
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
// ---
// Host and controller joined on one link.
// ---
module tb_top;
  logic clk_i = 1'b0, rst_n_i = 1'b0, load = 1'b0, go = 1'b0, rd = 1'b0, rdev = 1'b0, poff = 1'b0, len = 1'b0;
  logic ddone, hdone, nack, irq, sv, rrdy, poff_o, sclk, ssel, sdo, soe;
  logic [3:0] code = 4'hf, pg = 4'h0, pgo;
  logic [7:0] ev = 8'h00, en = 8'h00, cok = 8'h00, cm = 8'h00;
  logic [119:0] drx, hrx, tm = 120'h0123456789abcdeffedcba98765432, rm = 120'h00112233445566778899aabbccddee;
  int errors = 0, n_checks = 0, ndone = 0;
  phc_if lnk();
  phc_device phc_device_i (.clk_i, .rst_n_i, .link(lnk), .address_sense_input_i(code), .reply_msg_i(rm),
    .reply_load_i(load), .rx_msg_o(drx), .rx_done_o(ddone), .event_i(ev), .event_en_i(en), .cond_ok_i(cok),
    .cond_mask_i(cm), .led_pattern_i(16'hc3a5), .led_enable_i(len), .power_good_in_1_i(pg[0]),
    .power_good_in_2_i(pg[1]), .power_good_in_3_i(pg[2]), .power_good_in_4_i(pg[3]), .power_good_o(pgo),
    .ports_off_o(poff_o), .status_stream_clock_o(sclk), .status_stream_select_n_o(ssel),
    .status_stream_dout_o(sdo), .status_stream_out_en_n_o(soe));
  phc_host phc_host_i (.clk_i, .rst_n_i, .link(lnk), .addr_i(7'h3c), .go_i(go), .rd_i(rd), .tx_msg_i(tm),
    .rx_msg_o(hrx), .done_o(hdone), .nack_o(nack), .busy_o(), .reply_ready_o(rrdy), .irq_o(irq),
    .system_valid_o(sv), .reset_dev_i(rdev), .ports_off_i(poff));
  phc_checker phc_checker_i (.clk_i, .rst_n_i, .scl(lnk.scl), .dev_sda_oe(lnk.dev_sda_oe), .irq_oe(lnk.irq_oe),
    .system_valid_n(lnk.system_valid_n), .reply_pending_n(lnk.reply_pending_n), .host_reset_n(lnk.host_reset_n));
  // Free-running system clock.
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  // Counts the messages the controller reports as received.
  always @(posedge clk_i) ndone <= ndone + int'(ddone === 1'b1);
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask
  // Waits some edges, then lets their updates settle.
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Runs one host transfer and waits for its end under a bound.
  task automatic xfer(input logic r);
    int i;
    @(posedge clk_i);
    rd <= r;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    for (i = 0; i < 60000 && hdone !== 1'b1; i++) w(1);
    if (hdone !== 1'b1) begin
      errors++;
      report_and_stop;
    end
  endtask
  // Write at the top address, then one the controller must refuse.
  task automatic t_write;
    xfer(1'b0);
    chk(nack, 1'b0);
    chk(drx, tm);
    @(posedge clk_i);
    code <= 4'h1;
    xfer(1'b0);
    chk(nack, 1'b1);
    chk(ndone, 1);
    @(posedge clk_i);
    code <= 4'hf;
  endtask
  // Reply handshake, then a host reset of a pending reply.
  task automatic t_read;
    w(1);
    chk(rrdy, 1'b0);
    @(posedge clk_i);
    load <= 1'b1;
    @(posedge clk_i);
    load <= 1'b0;
    w(8);
    chk({lnk.reply_pending_n, rrdy}, 2'h1);
    xfer(1'b1);
    chk(hrx, rm);
    w(8);
    chk(lnk.reply_pending_n, 1'b1);
    @(posedge clk_i);
    load <= 1'b1;
    @(posedge clk_i);
    load <= 1'b0;
    w(10);
    chk(lnk.reply_pending_n, 1'b0);
    @(posedge clk_i);
    rdev <= 1'b1;
    w(12);
    chk({lnk.host_reset_n, lnk.reply_pending_n}, 2'h1);
    @(posedge clk_i);
    rdev <= 1'b0;
    w(12);
  endtask
  // Interrupt, system-valid, port shutdown and power-good levels.
  task automatic t_status;
    @(posedge clk_i);
    ev <= 8'h81;
    cok <= 8'h0f;
    cm <= 8'h0f;
    pg <= 4'h9;
    poff <= 1'b1;
    len <= 1'b1;
    w(10);
    chk({irq, sv, poff_o, soe, lnk.all_ports_off_n, pgo}, 9'h0c9);
    @(posedge clk_i);
    en <= 8'h80;
    cm <= 8'h1f;
    poff <= 1'b0;
    w(10);
    chk({irq, lnk.host_irq_n, sv, lnk.system_valid_n, poff_o}, 5'h12);
  endtask
  // Captures one whole status frame at the clock rises.
  task automatic t_led;
    logic [15:0] s;
    logic p, pd, seen;
    int b, i;
    s = 16'h0000;
    seen = 1'b0;
    b = 0;
    for (i = 0; i < 5000 && b < 16; i++) begin
      p = sclk;
      pd = sdo;
      w(1);
      if (ssel === 1'b1) seen = 1'b1;
      else if (seen && p === 1'b0 && sclk === 1'b1) begin
        s = {s[14:0], pd};
        b++;
      end
    end
    chk(s, 16'hc3a5);
  endtask
  task automatic report_and_stop;
    if (errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    w(12);
    t_write;
    t_read;
    t_status;
    t_led;
    report_and_stop;
  end
endmodule
